// file: sim/cpu_model.sv
`timescale 1ns/10ps
`default_nettype none

module cpu_model (
  input wire logic clk,
  input wire logic rstn,
  input wire logic go,
  input wire logic inhibit,
  input wire pil_pkg::vector_answer_type vector_answer,
  output logic vector_fetch,
  output logic [15:0] seen_addr,
  output logic seen_default,
  output logic seen
);
  // ---------------------------------------------------------------
  // processor side of the vector fetch
  // ---------------------------------------------------------------
  // single-cycle fetch; a set inhibit flag keeps the core off the vector
  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
      vector_fetch <= 1'b0;
    else
      vector_fetch <= go && !inhibit && !vector_fetch;
  end

  // capture the answer; a new fetch forgets the old one
  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
    begin
      seen <= 1'b0;
      seen_addr <= 16'h0000;
      seen_default <= 1'b0;
    end
    else if (go)
      seen <= 1'b0;
    else if (vector_answer.strobe)
    begin
      seen <= 1'b1;
      seen_addr <= vector_answer.addr;
      seen_default <= vector_answer.is_default;
    end
  end
endmodule // cpu_model

`default_nettype wire

// file: sim/pil_properties.sv
`timescale 1ns/10ps
`default_nettype none

module pil_properties (
  input wire logic clk,
  input wire logic rstn,
  input wire logic [7:0] paddr,
  input wire logic psel,
  input wire logic penable,
  input wire logic pready,
  input wire logic pslverr,
  input wire pil_pkg::request_lines_type req_lines,
  input wire logic vector_fetch,
  input wire pil_pkg::vector_answer_type vector_answer,
  input wire logic cpu_irq
);
  // ---------------------------------------------------------------
  // bus, vector and request checks
  // ---------------------------------------------------------------
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!rstn);

  AST_PREADY_WAIT: assert property (psel && penable && !pready |=> pready)
    else $error("ready missing after access phase");
  AST_PREADY_ONE: assert property (pready |=> !pready)
    else $error("ready held longer than one cycle");
  AST_SLVERR_UNMAPPED: assert property (pready && paddr > 8'h2C |-> pslverr)
    else $error("no error for unmapped address");
  AST_FETCH_ANSWER: assert property (vector_fetch |=> vector_answer.strobe)
    else $error("no vector answer after fetch");
  AST_STROBE_CAUSE: assert property (vector_answer.strobe |-> $past(vector_fetch))
    else $error("vector answer without fetch");
  AST_DEFAULT_ADDR: assert property (vector_answer.strobe && vector_answer.is_default
    |-> vector_answer.addr == pil_pkg::DEFAULT_VECTOR)
    else $error("default vector address wrong");
  AST_VALID_RANGE: assert property (vector_answer.strobe && !vector_answer.is_default
    |-> !vector_answer.addr[0] && vector_answer.addr >= pil_pkg::VECTOR_BASE
    && vector_answer.addr <= pil_pkg::VECTOR_BASE + 16'h000E)
    else $error("valid vector out of range");
  AST_TOP_LINE: assert property (vector_fetch && $past(req_lines.link[0])
    |=> !vector_answer.is_default
    && vector_answer.addr == pil_pkg::VECTOR_BASE + 16'h000E)
    else $error("top line did not win the fetch");
  AST_IRQ_LINK: assert property ($past(req_lines.link[0], 2) |-> cpu_irq)
    else $error("processor request missing for top line");

  // main scenarios reached
  cover property (vector_answer.strobe && vector_answer.is_default);
  cover property (vector_answer.strobe && !vector_answer.is_default);
  cover property (pready && pslverr);
endmodule // pil_properties

bind prioritized_interrupt_logic pil_properties i_props (
  .clk(clk),
  .rstn(rstn),
  .paddr(paddr),
  .psel(psel),
  .penable(penable),
  .pready(pready),
  .pslverr(pslverr),
  .req_lines(req_lines),
  .vector_fetch(vector_fetch),
  .vector_answer(vector_answer),
  .cpu_irq(cpu_irq)
);

`default_nettype wire

// file: sim/tb_prioritized_interrupt_logic.sv
`timescale 1ns/10ps
`default_nettype none

module tb_prioritized_interrupt_logic;
  // ---------------------------------------------------------------
  // bench
  // ---------------------------------------------------------------
  localparam int T1 = 5;
  localparam int T2 = 3;
  logic clk, rstn, psel, penable, pwrite, go, inhibit, err;
  logic pready, pslverr, cpu_irq, irq, vector_fetch, seen, seen_default;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic [15:0] seen_addr;
  pil_pkg::request_lines_type req_lines;
  pil_pkg::vector_answer_type vector_answer;
  int fails, checked;

  prioritized_interrupt_logic #(.TIMER1_DIV(16'h0005), .TIMER2_DIV(16'h0003)) i_dut (
    .clk(clk), .rstn(rstn), .paddr(paddr), .psel(psel), .penable(penable),
    .pwrite(pwrite), .pwdata(pwdata), .pready(pready), .prdata(prdata),
    .pslverr(pslverr), .req_lines(req_lines), .vector_fetch(vector_fetch),
    .vector_answer(vector_answer), .cpu_irq(cpu_irq), .irq(irq));

  cpu_model i_cpu (
    .clk(clk), .rstn(rstn), .go(go), .inhibit(inhibit),
    .vector_answer(vector_answer), .vector_fetch(vector_fetch),
    .seen_addr(seen_addr), .seen_default(seen_default), .seen(seen));

  // 200 MHz clock
  initial
  begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end

  task automatic summarize;
    $display("compares %0d mismatches %0d", checked, fails);
    if (fails == 0 && checked > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checked++;
    if (got !== exp)
    begin
      fails++;
      $display("MISMATCH t=%0t seen=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic cyc(input int n);
    repeat (n) @(posedge clk);
  endtask

  // one transfer; request held until ready is seen at an edge
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    @(posedge clk);
    while (pready !== 1'b1)
      @(posedge clk);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge clk);
  endtask

  task automatic fetch(input logic [15:0] ea, input logic ed);
    go <= 1'b1;
    @(posedge clk);
    go <= 1'b0;
    @(posedge clk);
    while (seen !== 1'b1)
      @(posedge clk);
    chk(32'(seen_addr), 32'(ea));
    chk(32'(seen_default), 32'(ed));
  endtask

  // reset values and an unmapped place
  task automatic t_regs;
    apb(0, pil_pkg::OFF_TLOAD3, 0);
    chk(rd, 32'h0000_FFFF);
    apb(0, pil_pkg::OFF_MASK, 0);
    chk(rd, 32'h0000_0000);
    apb(0, 8'h40, 0);
    chk(32'(err), 32'h0000_0001);
    chk(rd, 32'h0000_0000);
  endtask

  // mask boundary, ranking and line sources
  task automatic t_priority;
    apb(1, pil_pkg::OFF_MASK, 32'h0000_0005);
    req_lines <= 6'b100000;
    cyc(3);
    chk(32'(cpu_irq), 0);
    req_lines <= 6'b110000;
    cyc(3);
    chk(32'(cpu_irq), 1);
    apb(0, pil_pkg::OFF_PENDING, 0);
    chk(32'(rd[11:0]), 32'h0000_0B30);
    fetch(pil_pkg::VECTOR_BASE + 16'h000A, 1'b0);
    apb(1, pil_pkg::OFF_MASK, 32'h0000_0006);
    fetch(pil_pkg::DEFAULT_VECTOR, 1'b1);
    apb(1, pil_pkg::OFF_MASK, 0);
    for (int c = 0; c < 4; c++)
    begin
      req_lines <= 6'(4 << c);
      cyc(3);
      apb(0, pil_pkg::OFF_PENDING, 0);
      chk(32'(rd[7:0]), 32'(8'h80 >> c));
      fetch(pil_pkg::VECTOR_BASE + 16'(14 - 2 * c), 1'b0);
    end
    req_lines <= 6'b000000;
    cyc(3);
  endtask

  // default fetch raises, masks and clears the interrupt
  task automatic t_default;
    apb(1, pil_pkg::OFF_IRQ_STATUS, 32'h0000_0007);
    apb(1, pil_pkg::OFF_IRQ_MASK, 32'h0000_0001);
    fetch(pil_pkg::DEFAULT_VECTOR, 1'b1);
    cyc(2);
    chk(32'(irq), 1);
    apb(1, pil_pkg::OFF_IRQ_MASK, 0);
    cyc(1);
    chk(32'(irq), 0);
    apb(0, pil_pkg::OFF_IRQ_STATUS, 0);
    chk(32'(rd[2:0]), 1);
    apb(1, pil_pkg::OFF_IRQ_MASK, 32'h0000_0001);
    cyc(1);
    chk(32'(irq), 1);
    apb(1, pil_pkg::OFF_IRQ_STATUS, 32'h0000_0001);
    cyc(1);
    chk(32'(irq), 0);
  endtask

  // pulse latches: latched when enabled, transparent when not
  task automatic t_latch;
    logic [31:0] en;
    logic [7:0] pb;
    for (int k = 0; k < 2; k++)
    begin
      en = (k == 0) ? 32'h0000_0010 : 32'h0000_0040;
      pb = (k == 0) ? 8'h08 : 8'h04;
      apb(1, pil_pkg::OFF_PORT_A, en);
      req_lines <= (k == 0) ? 6'b000010 : 6'b000001;
      @(posedge clk);
      req_lines <= 6'b000000;
      cyc(3);
      apb(0, pil_pkg::OFF_PENDING, 0);
      chk(32'(rd[7:0]), 32'(pb));
      apb(1, pil_pkg::OFF_PORT_A, 0);
      apb(0, pil_pkg::OFF_PENDING, 0);
      chk(32'(rd[7:0]), 0);
      req_lines <= (k == 0) ? 6'b000010 : 6'b000001;
      cyc(3);
      apb(0, pil_pkg::OFF_PENDING, 0);
      chk(32'(rd[7:0]), 32'(pb));
      req_lines <= 6'b000000;
      cyc(3);
    end
  endtask

  // a set inhibit flag keeps the core from fetching a vector
  task automatic t_inhibit;
    inhibit <= 1'b1;
    go <= 1'b1;
    @(posedge clk);
    go <= 1'b0;
    cyc(4);
    chk(32'(seen), 0);
    chk(32'(vector_answer.strobe), 0);
    inhibit <= 1'b0;
    @(posedge clk);
  endtask

  // software level on the lowest line
  task automatic t_soft;
    apb(1, pil_pkg::OFF_CRA, 32'h0000_0030);
    cyc(2);
    chk(32'(cpu_irq), 1);
    apb(0, pil_pkg::OFF_PENDING, 0);
    chk(32'(rd[8:0]), 32'h0000_0101);
    apb(1, pil_pkg::OFF_CRA, 32'h0000_0038);
    apb(0, pil_pkg::OFF_PENDING, 0);
    chk(32'(rd[7:0]), 0);
    apb(1, pil_pkg::OFF_CRA, 32'h0000_0010);
    apb(0, pil_pkg::OFF_PENDING, 0);
    chk(32'(rd[7:0]), 0);
  endtask

  // timer one alone, then timer two clocked by timer one
  task automatic t_timer;
    apb(1, pil_pkg::OFF_TCTRL, 32'h0000_0001);
    cyc(2 * T1);
    apb(0, pil_pkg::OFF_PENDING, 0);
    chk(32'(rd[1]), 1);
    apb(0, pil_pkg::OFF_IRQ_STATUS, 0);
    chk(32'(rd[2]), 1);
    apb(1, pil_pkg::OFF_TCTRL, 0);
    apb(1, pil_pkg::OFF_TFLAGS, 32'h0000_0007);
    apb(1, pil_pkg::OFF_TCTRL, 32'h0000_000B);
    apb(0, pil_pkg::OFF_TFLAGS, 0);
    chk(32'(rd[1]), 0);
    cyc(T1 * T2 + 2);
    apb(0, pil_pkg::OFF_TFLAGS, 0);
    chk(32'(rd[1]), 1);
    apb(1, pil_pkg::OFF_TCTRL, 0);
  endtask

  // watchdog
  initial
  begin
    #50000;
    fails++;
    summarize();
  end

  initial
  begin
    rstn = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0000_0000;
    req_lines = 6'b000000;
    go = 1'b0;
    inhibit = 1'b0;
    fails = 0;
    checked = 0;
    repeat (12) @(posedge clk);
    rstn <= 1'b1;
    @(posedge clk);
    t_regs();
    t_priority();
    t_default();
    t_latch();
    t_inhibit();
    t_soft();
    t_timer();
    summarize();
  end
endmodule // tb_prioritized_interrupt_logic

`default_nettype wire

// file: verilog/pil_pkg.sv
package pil_pkg;

  // ---------------------------------------------------------------
  // register offsets (byte addresses)
  // ---------------------------------------------------------------
  localparam int ADDR_W = 8;
  localparam logic [7:0] OFF_PORT_A = 8'h00;
  localparam logic [7:0] OFF_CRA = 8'h04;
  localparam logic [7:0] OFF_MASK = 8'h08;
  localparam logic [7:0] OFF_PENDING = 8'h0C;
  localparam logic [7:0] OFF_TLOAD1 = 8'h10;
  localparam logic [7:0] OFF_TLOAD2 = 8'h14;
  localparam logic [7:0] OFF_TLOAD3 = 8'h18;
  localparam logic [7:0] OFF_TCTRL = 8'h1C;
  localparam logic [7:0] OFF_TFLAGS = 8'h20;
  localparam logic [7:0] OFF_IRQ_STATUS = 8'h24;
  localparam logic [7:0] OFF_IRQ_MASK = 8'h28;
  localparam logic [7:0] OFF_VECTOR = 8'h2C;

  // ---------------------------------------------------------------
  // field positions
  // ---------------------------------------------------------------
  localparam int LATCH_A_BIT = 4;
  localparam int LATCH_B_BIT = 6;
  localparam int CRA_MODE_HI = 5;
  localparam int CRA_MODE_LO = 4;
  localparam int CRA_LEVEL_BIT = 3;
  localparam int LINE_SW = 0;
  localparam int LINE_TIMER = 1;
  localparam int LINE_B = 2;
  localparam int LINE_A = 3;
  localparam int LINE_LINK0 = 7;
  localparam int TCTRL_EN1 = 0;
  localparam int TCTRL_EN2 = 1;
  localparam int TCTRL_EN3 = 2;
  localparam int TCTRL_CHAIN = 3;
  localparam int EV_DEFAULT = 0;
  localparam int EV_VALID_FETCH = 1;
  localparam int EV_TIMER = 2;
  localparam int STATUS_W = 3;

  // ---------------------------------------------------------------
  // reset values and vectors
  // ---------------------------------------------------------------
  localparam logic [15:0] DEFAULT_VECTOR = 16'hFFF8;
  localparam logic [15:0] VECTOR_BASE = 16'hFFE8;
  localparam logic [15:0] TIMER1_DIV = 16'h5334;
  localparam logic [15:0] TIMER2_DIV = 16'h0032;
  localparam logic [15:0] TIMER3_DIV = 16'hFFFF;
  localparam logic [3:0] TCTRL_RESET = 4'h0;
  localparam logic [7:0] PORT_A_RESET = 8'h00;
  localparam logic [7:0] CRA_RESET = 8'h00;
  localparam logic [2:0] MASK_RESET = 3'h0;

  // ---------------------------------------------------------------
  // carriers and states
  // ---------------------------------------------------------------
  typedef struct packed {
    logic [3:0] link;
    logic pulse_a;
    logic pulse_b;
  } request_lines_type;

  typedef struct packed {
    logic strobe;
    logic is_default;
    logic [15:0] addr;
  } vector_answer_type;

  typedef enum logic [1:0] {
    BUS_IDLE = 2'b01,
    BUS_DONE = 2'b10
  } bus_state_type;

endpackage

// file: verilog/prioritized_interrupt_logic.sv
// Implementation choices: the register offsets and the APB interface to the registers.
`timescale 1ns/10ps
`default_nettype none

module prioritized_interrupt_logic #(
  parameter int TIMER_W = 16,
  parameter logic [15:0] TIMER1_DIV = pil_pkg::TIMER1_DIV,
  parameter logic [15:0] TIMER2_DIV = pil_pkg::TIMER2_DIV
) (
  input wire logic clk,
  input wire logic rstn,
  input wire logic [7:0] paddr,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] pwdata,
  output logic pready,
  output logic [31:0] prdata,
  output logic pslverr,
  input wire pil_pkg::request_lines_type req_lines,
  input wire logic vector_fetch,
  output pil_pkg::vector_answer_type vector_answer,
  output logic cpu_irq,
  output logic irq
);

  // ---------------------------------------------------------------
  // elaboration checks
  // ---------------------------------------------------------------
  if (TIMER_W < 8 || TIMER_W > 16)
  begin : g_bad_width
    $error("timer width must lie between 8 and 16");
  end

  // ---------------------------------------------------------------
  // helper functions
  // ---------------------------------------------------------------
  // keep only requests at or above the mask level
  function automatic logic [7:0] qualify(input logic [7:0] pend, input logic [2:0] level);
    logic [7:0] res;
    res = '0;
    for (int i = 0; i < 8; i++)
    begin
      res[i] = pend[i] && (3'(i) >= level);
    end
    return res;
  endfunction

  // index of the highest set bit, line seven wins
  function automatic logic [2:0] top_index(input logic [7:0] vec);
    logic [2:0] idx;
    idx = '0;
    for (int i = 0; i < 8; i++)
    begin
      if (vec[i])
      begin
        idx = 3'(i);
      end
    end
    return idx;
  endfunction

  // ---------------------------------------------------------------
  // declarations
  // ---------------------------------------------------------------
  pil_pkg::bus_state_type bus_state_r;
  logic access;
  logic wr_en;
  logic hit;
  logic [31:0] rd_data;
  logic [7:0] port_a_r;
  logic [7:0] cra_r;
  logic [2:0] mask_r;
  logic [TIMER_W-1:0] tload1_r;
  logic [TIMER_W-1:0] tload2_r;
  logic [TIMER_W-1:0] tload3_r;
  logic [3:0] tctrl_r;
  logic [2:0] tflags_r;
  logic [2:0] expire;
  logic [pil_pkg::STATUS_W-1:0] status_r;
  logic [pil_pkg::STATUS_W-1:0] status_mask_r;
  logic [pil_pkg::STATUS_W-1:0] events;
  logic latch_a_r;
  logic latch_b_r;
  logic [7:0] lines;
  logic [7:0] intr_reg_r;
  logic [7:0] valid_vec;
  logic any_valid;
  logic [2:0] top;
  logic sw_line;
  logic timer2_tick;
  logic [15:0] last_vector_r;

  // ---------------------------------------------------------------
  // apb slave
  // ---------------------------------------------------------------
  // one wait state: pready comes from a flop, so the answer is
  // registered at the edge where the access phase is first seen
  assign access = (bus_state_r == pil_pkg::BUS_IDLE) && psel && penable;
  // writes land at the edge where the master sees pready high
  assign wr_en = (bus_state_r == pil_pkg::BUS_DONE) && psel && penable && pwrite;

  // bus handshake state
  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
    begin
      bus_state_r <= pil_pkg::BUS_IDLE;
      pready <= 1'b0;
      prdata <= '0;
      pslverr <= 1'b0;
    end
    else
    begin
      case (bus_state_r)
        pil_pkg::BUS_IDLE:
        begin
          if (access)
          begin
            bus_state_r <= pil_pkg::BUS_DONE;
            pready <= 1'b1;
            prdata <= pwrite ? '0 : rd_data;
            pslverr <= !hit;
          end
        end
        pil_pkg::BUS_DONE:
        begin
          bus_state_r <= pil_pkg::BUS_IDLE;
          pready <= 1'b0;
          pslverr <= 1'b0;
        end
        default:
        begin
          bus_state_r <= pil_pkg::BUS_IDLE;
          pready <= 1'b0;
        end
      endcase
    end
  end

  // read decode; unmapped addresses answer zero with an error
  always_comb
  begin
    hit = 1'b1;
    rd_data = '0;
    case (paddr)
      pil_pkg::OFF_PORT_A: rd_data = {24'h00_0000, port_a_r};
      pil_pkg::OFF_CRA: rd_data = {24'h00_0000, cra_r};
      pil_pkg::OFF_MASK: rd_data = {29'h0000_0000, mask_r};
      pil_pkg::OFF_PENDING: rd_data = {20'h0_0000, top, any_valid, intr_reg_r};
      pil_pkg::OFF_TLOAD1: rd_data = 32'(tload1_r);
      pil_pkg::OFF_TLOAD2: rd_data = 32'(tload2_r);
      pil_pkg::OFF_TLOAD3: rd_data = 32'(tload3_r);
      pil_pkg::OFF_TCTRL: rd_data = {28'h000_0000, tctrl_r};
      pil_pkg::OFF_TFLAGS: rd_data = {29'h0000_0000, tflags_r};
      pil_pkg::OFF_IRQ_STATUS: rd_data = 32'(status_r);
      pil_pkg::OFF_IRQ_MASK: rd_data = 32'(status_mask_r);
      pil_pkg::OFF_VECTOR: rd_data = {16'h0000, last_vector_r};
      default: hit = 1'b0;
    endcase
  end

  // ---------------------------------------------------------------
  // control registers
  // ---------------------------------------------------------------
  // port A image, adapter control A and mask level
  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
    begin
      port_a_r <= pil_pkg::PORT_A_RESET;
      cra_r <= pil_pkg::CRA_RESET;
      mask_r <= pil_pkg::MASK_RESET;
    end
    else if (wr_en)
    begin
      if (paddr == pil_pkg::OFF_PORT_A)
      begin
        port_a_r <= pwdata[7:0];
      end
      if (paddr == pil_pkg::OFF_CRA)
      begin
        cra_r <= pwdata[7:0];
      end
      if (paddr == pil_pkg::OFF_MASK)
      begin
        mask_r <= pwdata[2:0];
      end
    end
  end

  // timer divisors and enables
  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
    begin
      tload1_r <= TIMER_W'(TIMER1_DIV);
      tload2_r <= TIMER_W'(TIMER2_DIV);
      tload3_r <= TIMER_W'(pil_pkg::TIMER3_DIV);
      tctrl_r <= pil_pkg::TCTRL_RESET;
    end
    else if (wr_en)
    begin
      if (paddr == pil_pkg::OFF_TLOAD1)
      begin
        tload1_r <= pwdata[TIMER_W-1:0];
      end
      if (paddr == pil_pkg::OFF_TLOAD2)
      begin
        tload2_r <= pwdata[TIMER_W-1:0];
      end
      if (paddr == pil_pkg::OFF_TLOAD3)
      begin
        tload3_r <= pwdata[TIMER_W-1:0];
      end
      if (paddr == pil_pkg::OFF_TCTRL)
      begin
        tctrl_r <= pwdata[3:0];
      end
    end
  end

  // ---------------------------------------------------------------
  // three-channel timer module
  // ---------------------------------------------------------------
  // timer two counts timer one expiries when chained, else clk
  assign timer2_tick = tctrl_r[pil_pkg::TCTRL_CHAIN] ? expire[0] : 1'b1;

  timer_channel #(.WIDTH(TIMER_W)) u_timer1 (
    .clk(clk),
    .rstn(rstn),
    .enable(tctrl_r[pil_pkg::TCTRL_EN1]),
    .tick(1'b1),
    .divisor(tload1_r),
    .expire_r(expire[0])
  );

  timer_channel #(.WIDTH(TIMER_W)) u_timer2 (
    .clk(clk),
    .rstn(rstn),
    .enable(tctrl_r[pil_pkg::TCTRL_EN2]),
    .tick(timer2_tick),
    .divisor(tload2_r),
    .expire_r(expire[1])
  );

  timer_channel #(.WIDTH(TIMER_W)) u_timer3 (
    .clk(clk),
    .rstn(rstn),
    .enable(tctrl_r[pil_pkg::TCTRL_EN3]),
    .tick(1'b1),
    .divisor(tload3_r),
    .expire_r(expire[2])
  );

  // expiry flags, write one to clear; a new expiry beats the clear
  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
    begin
      tflags_r <= '0;
    end
    else
    begin
      tflags_r <= (tflags_r & ~((wr_en && paddr == pil_pkg::OFF_TFLAGS) ? pwdata[2:0] : 3'h0))
                  | expire;
    end
  end

  // ---------------------------------------------------------------
  // request line sources
  // ---------------------------------------------------------------
  // control output is a plain level only in the 11x mode
  assign sw_line = cra_r[pil_pkg::CRA_MODE_HI] && cra_r[pil_pkg::CRA_MODE_LO]
                   && !cra_r[pil_pkg::CRA_LEVEL_BIT];

  // pulse latches; inputs are sampled on clk, so a pulse shorter
  // than one clk period may be missed
  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
    begin
      latch_a_r <= 1'b0;
      latch_b_r <= 1'b0;
    end
    else
    begin
      latch_a_r <= port_a_r[pil_pkg::LATCH_A_BIT] && (latch_a_r || req_lines.pulse_a);
      latch_b_r <= port_a_r[pil_pkg::LATCH_B_BIT] && (latch_b_r || req_lines.pulse_b);
    end
  end

  // line assembly, link channel 0 on line seven down to channel 3
  always_comb
  begin
    for (int c = 0; c < 4; c++)
    begin
      lines[pil_pkg::LINE_LINK0 - c] = req_lines.link[c];
    end
    lines[pil_pkg::LINE_A] = req_lines.pulse_a || latch_a_r;
    lines[pil_pkg::LINE_B] = req_lines.pulse_b || latch_b_r;
    lines[pil_pkg::LINE_TIMER] = |tflags_r;
    lines[pil_pkg::LINE_SW] = sw_line;
  end

  // ---------------------------------------------------------------
  // interrupt register and priority
  // ---------------------------------------------------------------
  // capture every cycle; the sources themselves hold their requests
  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
    begin
      intr_reg_r <= '0;
    end
    else
    begin
      intr_reg_r <= lines;
    end
  end

  assign valid_vec = qualify(intr_reg_r, mask_r);
  assign any_valid = |valid_vec;
  assign top = top_index(valid_vec);

  // processor request; the core's own inhibit flag gates service
  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
    begin
      cpu_irq <= 1'b0;
    end
    else
    begin
      cpu_irq <= any_valid;
    end
  end

  // ---------------------------------------------------------------
  // vector fetch
  // ---------------------------------------------------------------
  // the valid set is judged at the fetch itself, so a request that
  // fell away since cpu_irq rose lands on the default vector
  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
    begin
      vector_answer <= '0;
      last_vector_r <= pil_pkg::DEFAULT_VECTOR;
    end
    else
    begin
      vector_answer.strobe <= vector_fetch;
      if (vector_fetch)
      begin
        vector_answer.is_default <= !any_valid;
        vector_answer.addr <= any_valid ? pil_pkg::VECTOR_BASE + {12'h000, top, 1'b0}
                              : pil_pkg::DEFAULT_VECTOR;
        last_vector_r <= any_valid ? pil_pkg::VECTOR_BASE + {12'h000, top, 1'b0}
                         : pil_pkg::DEFAULT_VECTOR;
      end
    end
  end

  // ---------------------------------------------------------------
  // event status and interrupt output
  // ---------------------------------------------------------------
  always_comb
  begin
    events = '0;
    events[pil_pkg::EV_DEFAULT] = vector_fetch && !any_valid;
    events[pil_pkg::EV_VALID_FETCH] = vector_fetch && any_valid;
    events[pil_pkg::EV_TIMER] = |expire;
  end

  // sticky status, write one to clear, set wins over clear
  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
    begin
      status_r <= '0;
      status_mask_r <= '0;
    end
    else
    begin
      status_r <= (status_r & ~((wr_en && paddr == pil_pkg::OFF_IRQ_STATUS)
                  ? pwdata[pil_pkg::STATUS_W-1:0] : '0)) | events;
      if (wr_en && paddr == pil_pkg::OFF_IRQ_MASK)
      begin
        status_mask_r <= pwdata[pil_pkg::STATUS_W-1:0];
      end
    end
  end

  // level output from a flop, one cycle behind the status
  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
    begin
      irq <= 1'b0;
    end
    else
    begin
      irq <= |(status_r & status_mask_r);
    end
  end

endmodule // prioritized_interrupt_logic

`default_nettype wire

// file: verilog/timer_channel.sv
`timescale 1ns/10ps
`default_nettype none

module timer_channel #(
  parameter int WIDTH = 16
) (
  input wire logic clk,
  input wire logic rstn,
  input wire logic enable,
  input wire logic tick,
  input wire logic [WIDTH-1:0] divisor,
  output logic expire_r
);

  logic [WIDTH-1:0] count_r;

  // ---------------------------------------------------------------
  // divide tick by divisor: count divisor-1 down to zero
  // ---------------------------------------------------------------
  // a stopped timer preloads so that the first period is whole
  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
    begin
      count_r <= '0;
      expire_r <= 1'b0;
    end
    else if (!enable)
    begin
      count_r <= divisor - 1'b1;
      expire_r <= 1'b0;
    end
    else if (tick)
    begin
      expire_r <= (count_r == '0);
      count_r <= (count_r == '0) ? divisor - 1'b1 : count_r - 1'b1;
    end
    else
    begin
      expire_r <= 1'b0;
    end
  end

endmodule // timer_channel

`default_nettype wire
